//--- rtl/timer16_waveform_mode_control.sv
// Compare-output actions and waveform mode decode of a 16-bit timer with two
// compare channels, counter, compare buffers and capture, behind an APB slave.
// Assumes timer_tick_in is a one-cycle enable from an outside prescaler, and
// port level/direction inputs come from the ordinary port logic of each pin.
//
// Function
// - Nonzero action field puts waveform on pin, PWM toggle on A in modes 9,11,15 only
// - Pin driver enabled only by direction bit
// - Non-PWM: 00 off, toggle, low, high
// - Fast PWM 01 toggles A only mode 15
// - Fast PWM 10/11 non-inverting or inverting output
// - Fast PWM 10/11 compare equals TOP: ignore match
// - Dual-slope 01 toggles A in modes 9,11
// - Dual-slope 10 clears up, sets down
// - Force strobes act only in non-PWM modes
// - Force strobe gives immediate match using action
// - Force sets no flag, never clears counter
// - Force strobe bits always read zero
// - Mode is upper bits joined with lower
// - Normal and CLEAR_ON_MATCH_MODE tops, immediate update, MAX
// - Phase correct tops, update TOP, flag BOTTOM
// - Modes 8,9 update and flag at BOTTOM
// - Fast PWM tops, update TOP, flag TOP
// - Upper mode bits sit in control B 4:3
// - Capture as TOP disables input capture
//
// The APB interface to the registers and the register addresses were left to the implementer.
`default_nettype none

module timer16_waveform_mode_control (
    // Clock and reset
    input  wire logic                    sys_clk_in,
    input  wire logic                    rst_n_in,
    // APB slave
    input  wire logic                    psel_in,
    input  wire logic                    penable_in,
    input  wire logic                    pwrite_in,
    input  wire logic [7:0]              paddr_in,
    input  wire logic [31:0]             pwdata_in,
    output logic      [31:0]             prdata_out,
    output logic                         pready_out,
    output logic                         pslverr_out,
    // Timer events
    input  wire logic                    timer_tick_in,
    input  wire logic                    capture_input_pin_in,
    // Ordinary port function of the two compare pins
    input  wire logic                    port_a_level_in,
    input  wire logic                    port_a_dir_in,
    input  wire logic                    port_b_level_in,
    input  wire logic                    port_b_dir_in,
    // Pin drive
    output timer16_pkg::pin_drive_t      chan_a_pin_out,
    output timer16_pkg::pin_drive_t      chan_b_pin_out
);
    import timer16_pkg::*;

    // Next waveform level of one channel
    function automatic logic next_wave(input logic cur, input out_action_t act, input wave_mode_t m,
                                       input logic chan_a, input logic match, input logic force_evt,
                                       input logic top_evt, input logic down, input logic cmp_eq_top);
        logic nxt;
        nxt = cur;
        if (is_fast(m)) begin
            if (act == ACT_TOGGLE) begin
                if (match && chan_a && m == MODE_FAST_CMP)
                    nxt = ~cur;
            end else if (act != ACT_OFF) begin
                // TOP event and match drive opposite levels
                if (top_evt)
                    nxt = (act == ACT_LOW);
                else if (match && !cmp_eq_top)
                    nxt = (act == ACT_HIGH);
            end
        end else if (is_dual(m)) begin
            // Count direction picks the level at a match
            if (act == ACT_TOGGLE) begin
                if (match && chan_a && (m == MODE_PFC_CMP || m == MODE_PC_CMP))
                    nxt = ~cur;
            end else if (act != ACT_OFF && match) begin
                nxt = (act == ACT_HIGH) ^ down;
            end
        end else if (match || force_evt) begin
            // Real and forced matches share one decode
            case (act)
                ACT_TOGGLE: nxt = ~cur;
                ACT_LOW:    nxt = 1'b0;
                ACT_HIGH:   nxt = 1'b1;
                default:    nxt = cur;
            endcase
        end
        return nxt;
    endfunction : next_wave

    // Whether the waveform takes the pin from the port
    function automatic logic drives_pin(input out_action_t act, input wave_mode_t m, input logic chan_a);
        logic on;
        on = (act != ACT_OFF);
        // Toggle in PWM is legal on channel A only
        if (act == ACT_TOGGLE && is_fast(m))
            on = chan_a && m == MODE_FAST_CMP;
        if (act == ACT_TOGGLE && is_dual(m))
            on = chan_a && (m == MODE_PFC_CMP || m == MODE_PC_CMP);
        return on;
    endfunction : drives_pin

    logic [7:0]  ctrl_a_q;
    logic [7:0]  ctrl_b_q;
    logic [15:0] cmp_a_buf_q;
    logic [15:0] cmp_b_buf_q;
    logic [15:0] cmp_a_q;
    logic [15:0] cmp_b_q;
    logic [15:0] capture_q;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic        down_q;
    logic        down_d;
    logic        block_q;
    logic [3:0]  status_q;
    logic [3:0]  status_d;
    logic        wave_a_q;
    logic        wave_b_q;
    logic        cap_prev_q;
    logic        cap_armed_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;
    pin_drive_t  pin_a_q;
    pin_drive_t  pin_b_q;

    // Bus decode
    // One wait state: ready rises in the second access cycle
    wire        access_w   = psel_in & penable_in;
    wire        pready_d   = access_w & ~pready_q;
    wire        done_w     = access_w & pready_q;
    wire        wr_w       = done_w & pwrite_in;
    wire        addr_ok_w  = (paddr_in[1:0] == 2'h0) && (paddr_in <= OFS_STATUS);
    wire        wr_ctrl_a  = wr_w && paddr_in == OFS_CTRL_A;
    wire        wr_ctrl_b  = wr_w && paddr_in == OFS_CTRL_B;
    wire        wr_cmp_a   = wr_w && paddr_in == OFS_CMP_A;
    wire        wr_cmp_b   = wr_w && paddr_in == OFS_CMP_B;
    wire        wr_capture = wr_w && paddr_in == OFS_CAPTURE;
    wire        wr_count   = wr_w && paddr_in == OFS_COUNT;
    wire        wr_status  = wr_w && paddr_in == OFS_STATUS;
    wire [15:0] wdata16    = pwdata_in[15:0];

    // Mode decode
    wire wave_mode_t  mode_w  = wave_mode_t'({ctrl_b_q[CB_MODE_HI:CB_MODE_LO],
                                              ctrl_a_q[CA_MODE_HI:CA_MODE_LO]});
    wire out_action_t act_a_w = out_action_t'(ctrl_a_q[CA_ACT_A_HI:CA_ACT_A_LO]);
    wire out_action_t act_b_w = out_action_t'(ctrl_a_q[CA_ACT_B_HI:CA_ACT_B_LO]);
    wire        fast_w     = is_fast(mode_w);
    wire        dual_w     = is_dual(mode_w);
    wire        pwm_w      = fast_w | dual_w;
    wire        ctc_w      = mode_w == MODE_CTC_CMP || mode_w == MODE_CTC_CAPT;
    wire        upd_top_w  = dual_w && mode_w != MODE_PFC_CAPT && mode_w != MODE_PFC_CMP;
    // Reserved mode 13 falls through to the fixed maximum
    wire [15:0] top_w      = (mode_w == MODE_PC8  || mode_w == MODE_FAST8)  ? TOP_8BIT  :
                             (mode_w == MODE_PC9  || mode_w == MODE_FAST9)  ? TOP_9BIT  :
                             (mode_w == MODE_PC10 || mode_w == MODE_FAST10) ? TOP_10BIT :
                             top_is_capture(mode_w)                         ? capture_q :
                             (ctc_w || pwm_w)                               ? cmp_a_q   :
                             CNT_MAX;

    // Counter events
    wire at_top_w    = cnt_q == top_w;
    wire at_bottom_w = cnt_q == CNT_BOTTOM;
    wire tick_w      = timer_tick_in;
    wire top_evt_w   = tick_w & at_top_w & ~down_q;
    wire bot_evt_w   = tick_w & at_bottom_w & down_q;
    wire overflow_w  = dual_w ? bot_evt_w :
                       fast_w ? top_evt_w :
                       tick_w & (cnt_q == CNT_MAX);
    wire upd_evt_w   = fast_w    ? top_evt_w :
                       upd_top_w ? top_evt_w :
                       dual_w    ? bot_evt_w :
                       1'b1;
    wire match_a_w   = tick_w & ~block_q & (cnt_q == cmp_a_q);
    wire match_b_w   = tick_w & ~block_q & (cnt_q == cmp_b_q);
    // Strobes see the mode and actions held before this write
    wire force_a_w   = wr_ctrl_a & pwdata_in[CA_FORCE_A] & ~pwm_w;
    wire force_b_w   = wr_ctrl_a & pwdata_in[CA_FORCE_B] & ~pwm_w;

    // Buffered compare values
    wire [15:0] cmp_a_buf_d = wr_cmp_a ? wdata16 : cmp_a_buf_q;
    wire [15:0] cmp_b_buf_d = wr_cmp_b ? wdata16 : cmp_b_buf_q;

    // Capture edge, blocked while capture value is TOP
    wire cap_edge_w = ctrl_b_q[CB_EDGE] ? (capture_input_pin_in & ~cap_prev_q)
                                        : (~capture_input_pin_in & cap_prev_q);
    // No edge until one pin level has been sampled, so none right after reset
    wire capture_w  = cap_edge_w & cap_armed_q & ~top_is_capture(mode_w);

    // Counter and direction
    always_comb begin
        cnt_d  = cnt_q;
        down_d = down_q & dual_w;
        if (wr_count) begin
            cnt_d = wdata16;
        end else if (tick_w) begin
            if (dual_w) begin
                // The count turns at TOP and BOTTOM without holding either for an extra tick
                if (!down_q && at_top_w) begin
                    cnt_d  = cnt_q - CNT_ONE;
                    down_d = 1'b1;
                end else if (down_q && at_bottom_w) begin
                    cnt_d  = cnt_q + CNT_ONE;
                    down_d = 1'b0;
                end else begin
                    cnt_d = down_q ? cnt_q - CNT_ONE : cnt_q + CNT_ONE;
                end
            end else if ((fast_w || ctc_w) && at_top_w) begin
                // Only a real TOP clears; forced compares never reach here
                cnt_d = CNT_BOTTOM;
            end else begin
                cnt_d = cnt_q + CNT_ONE;
            end
        end
    end

    // Sticky flags, a set in the clearing cycle wins
    always_comb begin
        status_d = status_q & ~(wr_status ? pwdata_in[3:0] : 4'h0);
        status_d[ST_OVERFLOW] = status_d[ST_OVERFLOW] | overflow_w;
        status_d[ST_MATCH_A]  = status_d[ST_MATCH_A] | match_a_w;
        status_d[ST_MATCH_B]  = status_d[ST_MATCH_B] | match_b_w;
        status_d[ST_CAPTURE]  = status_d[ST_CAPTURE] | capture_w;
    end

    // Read selection
    // Strobe bits are dropped at write, so they read zero
    wire [31:0] rd_data_w = (paddr_in == OFS_CTRL_A)  ? {24'h0, ctrl_a_q} :
                            (paddr_in == OFS_CTRL_B)  ? {24'h0, ctrl_b_q} :
                            (paddr_in == OFS_CMP_A)   ? {16'h0, cmp_a_buf_q} :
                            (paddr_in == OFS_CMP_B)   ? {16'h0, cmp_b_buf_q} :
                            (paddr_in == OFS_CAPTURE) ? {16'h0, capture_q} :
                            (paddr_in == OFS_COUNT)   ? {16'h0, cnt_q} :
                            (paddr_in == OFS_STATUS)  ? {28'h0, status_q} :
                            32'h0;

    // Pin drive
    wire pin_a_take = drives_pin(act_a_w, mode_w, 1'b1);
    wire pin_b_take = drives_pin(act_b_w, mode_w, 1'b0);
    wire wave_a_d   = next_wave(wave_a_q, act_a_w, mode_w, 1'b1, match_a_w, force_a_w,
                                top_evt_w, down_q, cmp_a_q == top_w);
    wire wave_b_d   = next_wave(wave_b_q, act_b_w, mode_w, 1'b0, match_b_w, force_b_w,
                                top_evt_w, down_q, cmp_b_q == top_w);
    // Direction input alone enables the driver
    wire pin_drive_t pin_a_d = '{level:    pin_a_take ? wave_a_d : port_a_level_in,
                                 oe:       port_a_dir_in,
                                 override: pin_a_take};
    wire pin_drive_t pin_b_d = '{level:    pin_b_take ? wave_b_d : port_b_level_in,
                                 oe:       port_b_dir_in,
                                 override: pin_b_take};

    // Bus answer
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end else begin
            pready_q  <= pready_d;
            pslverr_q <= pready_d & ~addr_ok_w;
            prdata_q  <= (pready_d && !pwrite_in) ? rd_data_w : 32'h0;
        end
    end

    // Control registers, strobe bits never stored
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_a_q <= CTRL_RESET;
            ctrl_b_q <= CTRL_RESET;
        end else begin
            if (wr_ctrl_a)
                ctrl_a_q <= pwdata_in[7:0] & CTRL_A_WMASK;
            if (wr_ctrl_b)
                ctrl_b_q <= pwdata_in[7:0] & CTRL_B_WMASK;
        end
    end

    // Compare buffers and active compare values
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cmp_a_buf_q <= VALUE_RESET;
            cmp_b_buf_q <= VALUE_RESET;
            cmp_a_q     <= VALUE_RESET;
            cmp_b_q     <= VALUE_RESET;
        end else begin
            cmp_a_buf_q <= cmp_a_buf_d;
            cmp_b_buf_q <= cmp_b_buf_d;
            if (upd_evt_w) begin
                cmp_a_q <= cmp_a_buf_d;
                cmp_b_q <= cmp_b_buf_d;
            end
        end
    end

    // Counter, capture and flags
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q      <= VALUE_RESET;
            down_q     <= 1'b0;
            block_q    <= 1'b0;
            capture_q  <= VALUE_RESET;
            cap_prev_q <= 1'b0;
            cap_armed_q <= 1'b0;
            status_q   <= STATUS_RESET;
        end else begin
            cnt_q      <= cnt_d;
            down_q     <= down_d;
            // A counter write removes any match at the next tick on both channels
            block_q    <= wr_count | (block_q & ~tick_w);
            cap_prev_q <= capture_input_pin_in;
            cap_armed_q <= 1'b1;
            status_q   <= status_d;
            if (capture_w)
                capture_q <= cnt_q;
            else if (wr_capture)
                capture_q <= wdata16;
        end
    end

    // Waveform state and pin registers
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wave_a_q <= 1'b0;
            wave_b_q <= 1'b0;
            pin_a_q  <= '0;
            pin_b_q  <= '0;
        end else begin
            wave_a_q <= wave_a_d;
            wave_b_q <= wave_b_d;
            pin_a_q  <= pin_a_d;
            pin_b_q  <= pin_b_d;
        end
    end

    assign prdata_out     = prdata_q;
    assign pready_out     = pready_q;
    assign pslverr_out    = pslverr_q;
    assign chan_a_pin_out = pin_a_q;
    assign chan_b_pin_out = pin_b_q;

endmodule : timer16_waveform_mode_control

`default_nettype wire

//--- rtl/timer16_pkg.sv
// Constants, types and mode decode helpers for the 16-bit timer waveform control.
// Assumes an APB slave wrapper with 32-bit data and byte addresses.
`default_nettype none

package timer16_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL_A  = 8'h00;
    localparam logic [7:0] OFS_CTRL_B  = 8'h04;
    localparam logic [7:0] OFS_CMP_A   = 8'h08;
    localparam logic [7:0] OFS_CMP_B   = 8'h0c;
    localparam logic [7:0] OFS_CAPTURE = 8'h10;
    localparam logic [7:0] OFS_COUNT   = 8'h14;
    localparam logic [7:0] OFS_STATUS  = 8'h18;

    // timer_ctrl_a fields
    localparam int CA_ACT_A_HI  = 7;
    localparam int CA_ACT_A_LO  = 6;
    localparam int CA_ACT_B_HI  = 5;
    localparam int CA_ACT_B_LO  = 4;
    localparam int CA_FORCE_A   = 3;
    localparam int CA_FORCE_B   = 2;
    localparam int CA_MODE_HI   = 1;
    localparam int CA_MODE_LO   = 0;
    localparam logic [7:0] CTRL_A_WMASK = 8'hf3;
    // timer_ctrl_b fields
    localparam int CB_EDGE      = 6;
    localparam int CB_MODE_HI   = 4;
    localparam int CB_MODE_LO   = 3;
    localparam logic [7:0] CTRL_B_WMASK = 8'h58;
    // Status fields, write one to clear
    localparam int ST_OVERFLOW  = 0;
    localparam int ST_MATCH_A   = 1;
    localparam int ST_MATCH_B   = 2;
    localparam int ST_CAPTURE   = 3;

    // Reset values and counter limits
    localparam logic [7:0]  CTRL_RESET   = 8'h00;
    localparam logic [15:0] VALUE_RESET  = 16'h0000;
    localparam logic [3:0]  STATUS_RESET = 4'h0;
    localparam logic [15:0] CNT_BOTTOM   = 16'h0000;
    localparam logic [15:0] CNT_MAX      = 16'hffff;
    localparam logic [15:0] CNT_ONE      = 16'h0001;
    localparam logic [15:0] TOP_8BIT     = 16'h00ff;
    localparam logic [15:0] TOP_9BIT     = 16'h01ff;
    localparam logic [15:0] TOP_10BIT    = 16'h03ff;

    typedef enum logic [3:0] {
        MODE_NORMAL    = 4'h0,
        MODE_PC8       = 4'h1,
        MODE_PC9       = 4'h2,
        MODE_PC10      = 4'h3,
        MODE_CTC_CMP   = 4'h4,
        MODE_FAST8     = 4'h5,
        MODE_FAST9     = 4'h6,
        MODE_FAST10    = 4'h7,
        MODE_PFC_CAPT  = 4'h8,
        MODE_PFC_CMP   = 4'h9,
        MODE_PC_CAPT   = 4'ha,
        MODE_PC_CMP    = 4'hb,
        MODE_CTC_CAPT  = 4'hc,
        MODE_RESERVED  = 4'hd,
        MODE_FAST_CAPT = 4'he,
        MODE_FAST_CMP  = 4'hf
    } wave_mode_t;

    typedef enum logic [1:0] {
        ACT_OFF    = 2'h0,
        ACT_TOGGLE = 2'h1,
        ACT_LOW    = 2'h2,
        ACT_HIGH   = 2'h3
    } out_action_t;

    typedef struct packed {
        logic level;
        logic oe;
        logic override;
    } pin_drive_t;

    function automatic logic is_fast(input wave_mode_t m);
        return m inside {MODE_FAST8, MODE_FAST9, MODE_FAST10, MODE_FAST_CAPT, MODE_FAST_CMP};
    endfunction : is_fast

    function automatic logic is_dual(input wave_mode_t m);
        return m inside {MODE_PC8, MODE_PC9, MODE_PC10, MODE_PFC_CAPT, MODE_PFC_CMP,
                         MODE_PC_CAPT, MODE_PC_CMP};
    endfunction : is_dual

    function automatic logic top_is_capture(input wave_mode_t m);
        return m inside {MODE_PFC_CAPT, MODE_PC_CAPT, MODE_CTC_CAPT, MODE_FAST_CAPT};
    endfunction : top_is_capture

endpackage : timer16_pkg

`default_nettype wire

//--- testbench/timer16_wmc_sva.sv
// Checker for APB timing and pin drive of the timer waveform block.
// Sees only the top module's ports; bound at the foot of this file.
`default_nettype none
module timer16_wmc_sva (
    // Clock and reset
    input wire logic                   sys_clk_in,
    input wire logic                   rst_n_in,
    // APB
    input wire logic                   psel_in,
    input wire logic                   penable_in,
    input wire logic                   pwrite_in,
    input wire logic [7:0]             paddr_in,
    input wire logic [31:0]            prdata_out,
    input wire logic                   pready_out,
    input wire logic                   pslverr_out,
    // Pins
    input wire logic                   port_a_level_in,
    input wire logic                   port_a_dir_in,
    input wire logic                   port_b_dir_in,
    input wire timer16_pkg::pin_drive_t chan_a_pin_out,
    input wire timer16_pkg::pin_drive_t chan_b_pin_out
);
    import timer16_pkg::*;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    apb_wait_a: assert property (psel_in && !penable_in |-> ##1 !pready_out ##1 pready_out)
        else $error("pready not in second access cycle");
    ready_pulse_a: assert property (pready_out |=> !pready_out)
        else $error("pready longer than one cycle");
    rdata_idle_a: assert property (!pready_out |-> prdata_out == 32'h0)
        else $error("read data outside answer cycle");
    err_addr_a: assert property (pready_out |-> pslverr_out == (paddr_in[1:0] != 2'h0 || paddr_in > 8'h18))
        else $error("slave error does not match address");
    err_data_a: assert property (pslverr_out |-> prdata_out == 32'h0)
        else $error("refused read returns data");
    dir_oe_a: assert property ($past(rst_n_in) |-> chan_a_pin_out.oe == $past(port_a_dir_in) &&
        chan_b_pin_out.oe == $past(port_b_dir_in))
        else $error("pin driver enable differs from direction");
    port_level_a: assert property ($past(rst_n_in) && !chan_a_pin_out.override |->
        chan_a_pin_out.level == $past(port_a_level_in))
        else $error("released pin not at port level");
    mode_change_a: assert property ($changed(chan_a_pin_out.override) |->
        $past(pready_out && pwrite_in) || $past(pready_out && pwrite_in, 2))
        else $error("pin ownership changed without a write");
endmodule : timer16_wmc_sva

bind timer16_waveform_mode_control timer16_wmc_sva i_sva (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .port_a_level_in(port_a_level_in), .port_a_dir_in(port_a_dir_in),
    .port_b_dir_in(port_b_dir_in), .chan_a_pin_out(chan_a_pin_out), .chan_b_pin_out(chan_b_pin_out)
);
`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench for the timer waveform mode control block.
// Drives APB, tick and port inputs itself; no far-side model.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import timer16_pkg::*;

    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] r; logic e;} reg_row_t;
    typedef struct {logic [7:0] ca; pin_drive_t pa; pin_drive_t pb;} frc_row_t;
    typedef struct {logic [7:0] cb; logic [7:0] ca; logic [1:0] ov;} ov_row_t;
    typedef struct {logic [7:0] cb; logic [7:0] ca; logic [31:0] cmp; int win; int hi;} pwm_row_t;

    logic        sys_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic        tick    = 1'b0;
    logic        pad     = 1'b1;
    logic        pbd     = 1'b1;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd_q;
    logic        pready;
    logic        pslverr;
    logic        err_q;
    pin_drive_t  pin_a;
    pin_drive_t  pin_b;
    int          bad_count  = 0;
    int          num_checks = 0;
    int          hi;

    reg_row_t regs[8] = '{'{8'h00, 32'hff, 32'hf3, 1'b0}, '{8'h04, 32'hff, 32'h58, 1'b0},
        '{8'h08, 32'h1234abcd, 32'habcd, 1'b0}, '{8'h0c, 32'hffff5a5a, 32'h5a5a, 1'b0},
        '{8'h10, 32'hc3, 32'hc3, 1'b0}, '{8'h14, 32'h77, 32'h77, 1'b0},
        '{8'h1c, 32'h1, 32'h0, 1'b1}, '{8'h02, 32'h1, 32'h0, 1'b1}};
    frc_row_t frc[5] = '{'{8'h48, 3'h7, 3'h6}, '{8'ha8, 3'h3, 3'h3}, '{8'he8, 3'h7, 3'h3},
        '{8'h48, 3'h3, 3'h6}, '{8'h14, 3'h6, 3'h7}};
    ov_row_t ovs[9] = '{'{8'h18, 8'h53, 2'h2}, '{8'h08, 8'h51, 2'h0}, '{8'h10, 8'h51, 2'h2},
        '{8'h10, 8'h53, 2'h2}, '{8'h00, 8'h51, 2'h0}, '{8'h18, 8'h52, 2'h0},
        '{8'h00, 8'h50, 2'h3}, '{8'h18, 8'h50, 2'h3}, '{8'h18, 8'h51, 2'h3}};
    pwm_row_t pwm[4] = '{'{8'h08, 8'h81, 32'h10, 256, 17}, '{8'h08, 8'hc1, 32'h10, 256, 239},
        '{8'h08, 8'h81, 32'hff, 256, 256}, '{8'h00, 8'h81, 32'h10, 510, 32}};

    always #50 sys_clk = ~sys_clk;

    timer16_waveform_mode_control i_dut (
        .sys_clk_in(sys_clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .timer_tick_in(tick), .capture_input_pin_in(1'b0),
        .port_a_level_in(pad), .port_a_dir_in(pad), .port_b_level_in(pbd), .port_b_dir_in(pbd),
        .chan_a_pin_out(pin_a), .chan_b_pin_out(pin_b)
    );

    task automatic test_done;
        $display("Checks %0d, mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            bad_count++;
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc

    // One APB transfer, waits for pready under a bound
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd_q    = prdata;
        err_q   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            bad_count++;
            test_done();
        end
    endtask : apb

    initial begin
        cyc(12);
        rst_n <= 1'b1;
        for (int i = 0; i <= 24; i += 4) begin
            apb(1'b0, 8'(i), 32'h0);
            chk(rd_q, 32'h0);
        end
        foreach (regs[i]) begin
            apb(1'b1, regs[i].a, regs[i].d);
            apb(1'b0, regs[i].a, 32'h0);
            chk(rd_q, regs[i].r);
            chk(32'(err_q), 32'(regs[i].e));
        end
        apb(1'b1, 8'h04, 32'h0);
        foreach (frc[i]) begin
            apb(1'b1, 8'h00, 32'(frc[i].ca & 8'hf3));
            apb(1'b1, 8'h00, 32'(frc[i].ca));
            cyc(3);
            chk(32'(pin_a), 32'(frc[i].pa));
            chk(32'(pin_b), 32'(frc[i].pb));
        end
        apb(1'b0, 8'h18, 32'h0);
        chk(rd_q, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk(rd_q, 32'h77);
        apb(1'b1, 8'h04, 32'h08);
        apb(1'b1, 8'h00, 32'hc9);
        cyc(3);
        chk(32'(pin_a), 32'h3);
        foreach (ovs[i]) begin
            apb(1'b1, 8'h04, 32'(ovs[i].cb));
            apb(1'b1, 8'h00, 32'(ovs[i].ca));
            cyc(3);
            chk(32'({pin_a.override, pin_b.override}), 32'(ovs[i].ov));
        end
        foreach (pwm[i]) begin
            apb(1'b1, 8'h08, pwm[i].cmp);
            apb(1'b1, 8'h04, 32'(pwm[i].cb));
            apb(1'b1, 8'h00, 32'(pwm[i].ca));
            apb(1'b1, 8'h18, 32'hf);
            tick <= 1'b1;
            cyc(1100);
            hi = 0;
            repeat (pwm[i].win) begin
                @(posedge sys_clk);
                if (pin_a.level === 1'b1) hi++;
            end
            chk(32'(hi), 32'(pwm[i].hi));
            apb(1'b0, 8'h18, 32'h0);
            chk(32'(rd_q[0]), 32'h1);
        end
        tick  <= 1'b0;
        pbd   <= 1'b0;
        rst_n <= 1'b0;
        cyc(3);
        chk(32'({pin_a, pin_b, pready}), 32'h0);
        rst_n <= 1'b1;
        cyc(2);
        chk(32'({pin_a, pin_b}), 32'h30);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd_q, 32'h0);
        test_done();
    end
endmodule : testbench
`default_nettype wire
